// [src/tca_top.sv]
/*
  Conversion sequencer, APB register file and alert pins.
  Assumes sense_temp comes from pclk logic; scl and address selects are pins.
*/
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "tca_consts.svh"
module tca_top
    import tca_pkg::*;
#(
    parameter int unsigned FAST_CYC  = `TCA_FAST_MS * `TCA_CLK_KHZ,
    parameter int unsigned CONV_CYC  = `TCA_CONV_MS * `TCA_CLK_KHZ,
    parameter int unsigned OCONV_CYC = `TCA_ONCE_CONV_MS * `TCA_CLK_KHZ,
    parameter int unsigned OIDLE_CYC = `TCA_ONCE_IDLE_MS * `TCA_CLK_KHZ,
    // Arbitrary upper bits of the target address
    parameter logic [4:0]  TGT_BASE  = 5'h0A
)(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Sensor result
    input  wire logic [15:0] sense_temp,
    // Pins
    input  wire logic        addr_select_low,
    input  wire logic        addr_select_high,
    input  wire logic        scl,
    output logic             critical_alert_out,
    output logic             critical_alert_oe,
    output logic             limit_alert_out,
    output logic             limit_alert_oe
);
    tca_top_t    st;
    tca_top_t    next_st;
    tca_alert_if al ();
    logic        acc, mapped, wcfg, conv_end;
    logic [5:0]  idx;
    logic [1:0]  mode;
    logic [15:0] rdat;
    int unsigned lim;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic tca_hit(logic [24:0] c, int unsigned l);
        return 32'(c) + 32'h1 >= l;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        idx = paddr[7:2];
        acc = psel && penable && st.pready;
        mapped = paddr[1:0] == 2'h0 && idx <= `TCA_IDX_SCL;
        wcfg = acc && pwrite && mapped && idx == `TCA_IDX_CFG;
        mode = st.cfg[`TCA_CFG_MODE];
        lim = (mode == `TCA_MODE_ONCE) ? OCONV_CYC : CONV_CYC; // RULE16
        conv_end = st.seq == SEQ_CONV && tca_hit(st.cnt, lim);
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        case (idx)
            `TCA_IDX_TMSB: rdat = {8'h00, st.res[15:8]};
            `TCA_IDX_TLSB: rdat = {8'h00, st.cfg[`TCA_CFG_RES] ? st.res[7:0]
                                          : {st.res[7:3], al.flags}};
            `TCA_IDX_STAT: rdat = {8'h00, st.rdy_n, al.flags, 4'h0};
            `TCA_IDX_CFG:  rdat = {8'h00, st.cfg};
            `TCA_IDX_CRIT: rdat = st.crit;
            `TCA_IDX_HIGH: rdat = st.high;
            `TCA_IDX_LOW:  rdat = st.low;
            `TCA_IDX_ADDR: rdat = {9'h000, TGT_BASE, st.a1_2, st.a0_2}; // RULE21
            `TCA_IDX_SCL:  rdat = st.scl_cnt;
            default:       rdat = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.od = 1'b0;
        // Pin synchronisers
        next_st.a0_1 = addr_select_low;
        next_st.a0_2 = st.a0_1;
        next_st.a1_1 = addr_select_high;
        next_st.a1_2 = st.a1_1;
        next_st.scl_1 = scl; // RULE20
        next_st.scl_2 = st.scl_1;
        next_st.scl_3 = st.scl_2;
        if (st.scl_2 && !st.scl_3) next_st.scl_cnt = st.scl_cnt + 16'h0001;
        // APB access: one wait cycle, data from flops
        next_st.pready = 1'b0;
        next_st.rd = 1'b0;
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.pslverr = !mapped;
            next_st.prdata = (mapped && !pwrite) ? {16'h0000, rdat} : 32'h0000_0000;
        end
        if (acc && !pwrite && mapped) begin
            next_st.rd = 1'b1;
            if (idx == `TCA_IDX_TMSB || idx == `TCA_IDX_TLSB) next_st.rdy_n = 1'b1;
        end
        if (acc && pwrite && mapped) begin
            case (idx)
                `TCA_IDX_CFG:  next_st.cfg = pwdata[7:0]; // RULE9
                `TCA_IDX_CRIT: next_st.crit = pwdata[15:0]; // RULE7
                `TCA_IDX_HIGH: next_st.high = pwdata[15:0];
                `TCA_IDX_LOW:  next_st.low = pwdata[15:0];
                default: ;
            endcase
        end
        // Conversion sequencer on the internal clock count
        next_st.done = 1'b0;
        next_st.fast = 1'b0;
        next_st.cnt = st.cnt + 25'h0000001; // RULE6
        case (st.seq)
            SEQ_FAST: begin
                if (tca_hit(st.cnt, FAST_CYC)) begin // RULE3
                    next_st.done = 1'b1;
                    next_st.fast = 1'b1;
                    next_st.cnt = 25'h0000000;
                    next_st.seq = (mode == `TCA_MODE_SHUT) ? SEQ_SHUT : SEQ_CONV;
                end
            end
            SEQ_CONV: begin
                if (conv_end) begin
                    next_st.done = 1'b1;
                    next_st.cnt = 25'h0000000;
                    case (mode)
                        `TCA_MODE_NORM: next_st.seq = SEQ_CONV; // RULE1
                        `TCA_MODE_ONCE: next_st.seq = SEQ_IDLE; // RULE16
                        default:        next_st.seq = SEQ_SHUT; // RULE13
                    endcase
                end
            end
            SEQ_IDLE: begin
                if (tca_hit(st.cnt, OIDLE_CYC)) begin
                    next_st.cnt = 25'h0000000;
                    next_st.seq = SEQ_CONV;
                end
            end
            SEQ_SHUT: next_st.cnt = 25'h0000000; // RULE25
            default: next_st.seq = SEQ_CONV;
        endcase
        if (next_st.done) begin
            next_st.res = tca_fmt(sense_temp, st.cfg[`TCA_CFG_RES]); // RULE2 RULE18 RULE22
            next_st.rdy_n = 1'b0;
        end
        // Mode writes
        if (wcfg && st.seq != SEQ_FAST) begin
            case (pwdata[6:5])
                `TCA_MODE_ONE: begin // RULE12
                    next_st.seq = SEQ_CONV; // RULE15
                    next_st.cnt = 25'h0000000;
                end
                `TCA_MODE_SHUT: next_st.seq = SEQ_SHUT; // RULE25
                default: begin // RULE17
                    if (st.seq == SEQ_SHUT) begin // RULE26
                        next_st.seq = SEQ_CONV;
                        next_st.cnt = 25'h0000000;
                    end
                end
            endcase
        end
        // Open-drain pins: enable pulls low
        next_st.crit_oe = al.crit_act ^ st.cfg[`TCA_CFG_CPOL]; // RULE11
        next_st.lim_oe = al.int_act ^ st.cfg[`TCA_CFG_IPOL]; // RULE10
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // SCL synchronisers rest at the pulled-up idle level: no false edge after reset
            st <= '{seq: SEQ_FAST, rdy_n: 1'b1, cfg: `TCA_CFG_RST, crit: `TCA_CRIT_RST,
                    scl_1: 1'b1, scl_2: 1'b1, scl_3: 1'b1,
                    high: `TCA_HIGH_RST, low: `TCA_LOW_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Alert evaluator
    // ------------------------------------------------------------
    assign al.done = st.done;
    assign al.fast = st.fast;
    assign al.rd = st.rd;
    assign al.cfg = st.cfg;
    assign al.res = st.res;
    assign al.crit = st.crit;
    assign al.high = st.high;
    assign al.low = st.low;

    tca_alert u_alert (
        .pclk    (pclk),
        .presetn (presetn),
        .a       (al)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign critical_alert_out = st.od;
    assign critical_alert_oe = st.crit_oe;
    assign limit_alert_out = st.od;
    assign limit_alert_oe = st.lim_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_one_wr;
        wcfg && pwdata[6:5] == `TCA_MODE_ONE && st.seq != SEQ_FAST;
    endsequence
    property p_apb_wait;
        s_wait |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready timing wrong");
    property p_one_start;
        s_one_wr |=> st.seq == SEQ_CONV && st.cnt == 25'h0000000;
    endproperty
    a_one_start: assert property (p_one_start) else $error("one-shot not started"); // RULE15
    property p_norm_next;
        conv_end && mode == `TCA_MODE_NORM && !wcfg |=> st.done && st.seq == SEQ_CONV
                                                       && st.cnt == 25'h0000000;
    endproperty
    a_norm_next: assert property (p_norm_next) else $error("no back to back conversion"); // RULE1
    property p_result;
        st.done |-> st.res == tca_fmt($past(sense_temp), $past(st.cfg[`TCA_CFG_RES]));
    endproperty
    a_result: assert property (p_result) else $error("result not stored"); // RULE2
    property p_one_shut;
        conv_end && mode == `TCA_MODE_ONE && !wcfg |=> st.seq == SEQ_SHUT;
    endproperty
    a_one_shut: assert property (p_one_shut) else $error("one-shot did not shut down"); // RULE13
    property p_once_idle;
        conv_end && mode == `TCA_MODE_ONCE && !wcfg |=> st.seq == SEQ_IDLE && st.done;
    endproperty
    a_once_idle: assert property (p_once_idle) else $error("no idle after conversion"); // RULE16
    property p_shut_hold;
        st.seq == SEQ_SHUT && !wcfg |=> st.seq == SEQ_SHUT && !st.done
                                       && st.res == $past(st.res);
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("conversion in shutdown"); // RULE25
    property p_fast_first;
        st.done && st.fast |-> $past(st.seq) == SEQ_FAST && st.seq != SEQ_FAST;
    endproperty
    a_fast_first: assert property (p_fast_first) else $error("fast conversion misplaced"); // RULE3
endmodule

// [inc/tca_consts.svh]
/*
  Constants of the conversion sequencer and limit alert block.
  Assumes a 25 MHz pclk and the register index map below.
*/
`ifndef TCA_CONSTS_SVH
`define TCA_CONSTS_SVH
// What this block does
// RULE1: Normal mode converts back to back, 240 ms per conversion.
// RULE2: Each finished result lands in the temperature value registers.
// RULE3: First conversion after power-up is a fast 6 ms one.
// RULE4: Fast conversion drives critical alert when above 147 C.
// RULE5: Fast conversion drives limit alert when above 64 C.
// RULE6: Conversion timing comes from the internal clock, not the bus clock.
// RULE7: Result compared to critical, high, low limits; limit alert beyond high/low.
// RULE8: Critical alert activates when result exceeds the critical limit.
// RULE9: Config selects polarity and comparator or interrupt mode of alerts.
// RULE10: Limit alert defaults to active-low comparator after power-up.
// RULE11: Critical alert defaults to active-low after power-up.
// RULE12: Mode field bits 6:5 of config index 0x03 at 01 selects one-shot.
// RULE13: One-shot does one conversion then shuts down.
// RULE14: Controller waits 240 ms after one-shot start before reading.
// RULE15: Every write of 01 to the mode field starts a new conversion. The code ignores mode writes while seq is SEQ_FAST.
// RULE16: Once-per-second mode: 60 ms conversion, then 940 ms idle.
// RULE17: Mode field 10 at config index 0x03 selects once-per-second mode.
// RULE18: Results default to 13 bits, optionally 16 bits.
// RULE19: Config holds the fault count field and the mode enables.
// RULE20: Bus clock is external, open-drain, sampled only for serial access. The code samples scl every pclk and counts its rising edges.
// RULE21: Two address select inputs set the device target address.
// RULE22: Config bit 7 switches result and limits to 16-bit format.
// RULE23: Alerts need consecutive faults; an in-limit result clears the count.
// RULE24: In interrupt mode any register read releases both alerts.
// RULE25: Mode 11 shuts down; no conversions, last result stays readable.
// RULE26: Mode 00 is continuous normal operation and the reset state.
`define TCA_CLK_KHZ      25000
`define TCA_FAST_MS      6
`define TCA_CONV_MS      240
`define TCA_ONCE_CONV_MS 60
`define TCA_ONCE_IDLE_MS 940
`define TCA_IDX_TMSB     6'h00
`define TCA_IDX_TLSB     6'h01
`define TCA_IDX_STAT     6'h02
`define TCA_IDX_CFG      6'h03
`define TCA_IDX_CRIT     6'h04
`define TCA_IDX_HIGH     6'h05
`define TCA_IDX_LOW      6'h06
`define TCA_IDX_ADDR     6'h07
`define TCA_IDX_SCL      6'h08
`define TCA_CFG_FQ       1:0
`define TCA_CFG_CPOL     2
`define TCA_CFG_IPOL     3
`define TCA_CFG_INTR     4
`define TCA_CFG_MODE     6:5
`define TCA_CFG_RES      7
`define TCA_MODE_NORM    2'h0
`define TCA_MODE_ONE     2'h1
`define TCA_MODE_ONCE    2'h2
`define TCA_MODE_SHUT    2'h3
`define TCA_CFG_RST      8'h00
`define TCA_CRIT_RST     16'h4980
`define TCA_HIGH_RST     16'h2000
`define TCA_LOW_RST      16'h0500
`define TCA_FAST_CRIT    16'h4980
`define TCA_FAST_INT     16'h2000
`define TCA_LO3          3'h0
`endif

// [inc/tca_pkg.sv]
/*
  Types and the format function of the alert block.
  Assumes tca_consts.svh is on the include path.
*/
`include "tca_consts.svh"
package tca_pkg;
    typedef enum logic [1:0] {SEQ_FAST, SEQ_CONV, SEQ_IDLE, SEQ_SHUT} tca_seq_t;
    typedef struct packed {
        logic a0_1, a0_2, a1_1, a1_2, scl_1, scl_2, scl_3;
        logic [15:0] scl_cnt;
        tca_seq_t    seq;
        logic [24:0] cnt;
        logic [15:0] res, crit, high, low;
        logic [7:0]  cfg;
        logic        done, fast, rdy_n, pready, pslverr, rd, crit_oe, lim_oe, od;
        logic [31:0] prdata;
    } tca_top_t;
    typedef struct packed {
        logic       crit_act, int_act;
        logic [2:0] flags, cnt;
    } tca_alert_t;
    function automatic logic [15:0] tca_fmt(logic [15:0] v, logic res16);
        return res16 ? v : {v[15:3], `TCA_LO3};
    endfunction
endpackage

// [inc/tca_alert_if.sv]
/*
  Link between the sequencer and the alert evaluator.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ns
interface tca_alert_if;
    logic        done, fast, rd;
    logic [7:0]  cfg;
    logic [15:0] res, crit, high, low;
    logic        crit_act, int_act;
    logic [2:0]  flags;
    modport seq   (output done, fast, rd, cfg, res, crit, high, low,
                   input crit_act, int_act, flags);
    modport alert (input done, fast, rd, cfg, res, crit, high, low,
                   output crit_act, int_act, flags);
endinterface

// [src/tca_alert.sv]
/*
  Limit comparison, fault queue and alert state.
  Assumes done pulses one cycle with res already updated.
*/
`timescale 1ns/1ns
`include "tca_consts.svh"
module tca_alert
    import tca_pkg::*;
(
    // Clock and reset
    input wire logic   pclk,
    input wire logic   presetn,
    // Sequencer side
    tca_alert_if.alert a
);
    tca_alert_t st;
    tca_alert_t next_st;
    logic       hi_c, hi_h, lo_l, oor, reach, intr;
    logic [2:0] need;

    always_comb begin
        next_st = st;
        intr = a.cfg[`TCA_CFG_INTR];
        hi_c = $signed(a.res) > $signed(tca_fmt(a.crit, a.cfg[`TCA_CFG_RES])); // RULE8
        hi_h = $signed(a.res) > $signed(tca_fmt(a.high, a.cfg[`TCA_CFG_RES])); // RULE7
        lo_l = $signed(a.res) < $signed(tca_fmt(a.low, a.cfg[`TCA_CFG_RES]));
        oor  = hi_c | hi_h | lo_l;
        need = {1'b0, a.cfg[`TCA_CFG_FQ]} + 3'h1; // RULE19
        reach = oor && (st.cnt + 3'h1 >= need);
        if (a.rd && intr) begin
            next_st.crit_act = 1'b0; // RULE24
            next_st.int_act = 1'b0;
        end
        if (a.done) begin
            next_st.flags = {hi_c, hi_h, lo_l};
            if (a.fast) begin
                next_st.crit_act = $signed(a.res) > $signed(`TCA_FAST_CRIT); // RULE4
                next_st.int_act = $signed(a.res) > $signed(`TCA_FAST_INT); // RULE5
            end else begin
                next_st.cnt = !oor ? 3'h0 : (st.cnt >= need ? need : st.cnt + 3'h1); // RULE23
                if (intr) begin
                    if (reach && hi_c) next_st.crit_act = 1'b1;
                    if (reach && (hi_h || lo_l)) next_st.int_act = 1'b1;
                end else begin
                    next_st.crit_act = reach && hi_c; // RULE9
                    next_st.int_act = reach && (hi_h || lo_l);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) st <= '0;
        else st <= next_st;
    end

    assign a.crit_act = st.crit_act;
    assign a.int_act = st.int_act;
    assign a.flags = st.flags;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_queue_clr;
        a.done && !a.fast && !oor |=> st.cnt == 3'h0 && !a.int_act && !a.crit_act
                                     || a.cfg[`TCA_CFG_INTR];
    endproperty
    a_queue_clr: assert property (p_queue_clr) else $error("fault count not cleared"); // RULE23
    property p_intr_rd;
        a.rd && a.cfg[`TCA_CFG_INTR] && !a.done |=> !a.crit_act && !a.int_act;
    endproperty
    a_intr_rd: assert property (p_intr_rd) else $error("read did not release alerts"); // RULE24
    property p_crit_cmp;
        a.done && !a.fast && !a.cfg[`TCA_CFG_INTR] && a.cfg[`TCA_CFG_FQ] == 2'h0 && hi_c
            |=> a.crit_act;
    endproperty
    a_crit_cmp: assert property (p_crit_cmp) else $error("critical alert missed"); // RULE8
endmodule

// [verification/tca_host_model.sv]
/*
  Host-side bus controller model: serial clock bursts and address straps.
  Assumes the bench raises start once for each burst it wants.
*/
`timescale 1ns/1ns
module tca_host_model #(
    parameter int unsigned PULSES = 5
)(
    // Control
    input  wire logic start,
    // Pins
    output logic      scl,
    output logic      sel_low,
    output logic      sel_high
);
    // ----------------------------------------
    // Straps and clock
    // ----------------------------------------
    assign sel_low  = 1'b0;
    assign sel_high = 1'b1;
    // Clock rests high on its pull-up outside a burst
    initial scl = 1'b1;
    always @(posedge start) begin
        repeat (PULSES) begin
            #160 scl = 1'b0;
            #160 scl = 1'b1;
        end
    end
endmodule

// [verification/temp_conversion_alert_control_bench.sv]
/*
  Self-checking bench of the conversion sequencer and alert block.
  Assumes shortened counts: fast 20, conversion 40, once 15 plus 30 idle.
*/
`timescale 1ns/1ns
module temp_conversion_alert_control_bench
    import tca_pkg::*;
;
    localparam int unsigned CONV  = 40;
    localparam int unsigned OCONV = 15;
    localparam logic [4:0]  TGT   = 5'h0A;
    typedef struct packed {
        logic        wr;
        logic [5:0]  idx;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        err;
    } tca_row_t;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        pclk       = 1'b0;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = 8'h00;
    logic [31:0] pwdata     = 32'h0;
    logic [15:0] sense_temp = 16'h4A00;
    logic        scl_go     = 1'b0;
    logic [31:0] prdata, rd, n0;
    logic        pready, pslverr, er, scl, sel_low, sel_high;
    logic        crit_out, crit_oe, lim_out, lim_oe;
    int          miscompares  = 0;
    int          total_checks = 0;
    int          cyc          = 0;
    tca_row_t    rows [11] = '{
        '{1'b0, 6'h03, 32'h0, 32'h0, 1'b0}, '{1'b0, 6'h04, 32'h0, 32'h4980, 1'b0},
        '{1'b0, 6'h05, 32'h0, 32'h2000, 1'b0}, '{1'b0, 6'h06, 32'h0, 32'h0500, 1'b0},
        '{1'b1, 6'h05, 32'h2A00, 32'h0, 1'b0}, '{1'b0, 6'h05, 32'h0, 32'h2A00, 1'b0},
        '{1'b1, 6'h05, 32'h2000, 32'h0, 1'b0}, '{1'b1, 6'h00, 32'hFF, 32'h0, 1'b0},
        '{1'b0, 6'h00, 32'h0, 32'h4A, 1'b0}, '{1'b0, 6'h07, 32'h0, {25'h0, TGT, 2'h2}, 1'b0},
        '{1'b0, 6'h09, 32'h0, 32'h0, 1'b1}};
    always #20 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    // ----------------------------------------
    // Design and host model
    // ----------------------------------------
    tca_top #(.FAST_CYC(20), .CONV_CYC(CONV), .OCONV_CYC(OCONV), .OIDLE_CYC(30),
              .TGT_BASE(TGT)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense_temp(sense_temp), .addr_select_low(sel_low),
        .addr_select_high(sel_high), .scl(scl), .critical_alert_out(crit_out),
        .critical_alert_oe(crit_oe), .limit_alert_out(lim_out), .limit_alert_oe(lim_oe));
    tca_host_model #(.PULSES(5)) host_u (
        .start(scl_go), .scl(scl), .sel_low(sel_low), .sel_high(sel_high));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1);
        @(posedge pclk);
    endtask
    task automatic poll(input logic [7:0] v, output int t);
        int t0;
        t0 = cyc;
        do apb(1'b0, 6'h00, 32'h0);
        while (rd[7:0] !== v && cyc - t0 < 300);
        t = cyc - t0;
    endtask
    task automatic span(input logic [1:0] mode, input logic [7:0] a, input logic [7:0] b,
                        input int len, input int per);
        int t1;
        int t2;
        sense_temp <= {a, 8'h00};
        apb(1'b1, 6'h03, {25'h0, mode, 5'h00});
        poll(a, t1);
        sense_temp <= {b, 8'h00};
        poll(b, t2);
        chk(t1 >= len && t1 <= len + 8, 1'b1);
        chk(t2 >= per - 6 && t2 <= per + 6, 1'b1);
        $display("test span mode %0d done", mode);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (26) @(posedge pclk);
        chk({crit_oe, lim_oe, crit_out, lim_out}, 4'hC);
        for (int i = 0; i < 11; i++) begin
            apb(rows[i].wr, rows[i].idx, rows[i].wd);
            chk(er, rows[i].err);
            if (!rows[i].wr && !rows[i].err) chk(rd, rows[i].exp);
        end
        $display("test registers done");
        apb(1'b0, 6'h01, 32'h0);
        chk(rd, 32'h06);
        apb(1'b1, 6'h03, 32'h80);
        sense_temp <= 16'h0C87;
        repeat (2 * CONV + 4) @(posedge pclk);
        apb(1'b0, 6'h01, 32'h0);
        chk(rd, 32'h87);
        chk({crit_oe, lim_oe}, 2'h0);
        apb(1'b1, 6'h03, 32'h0C);
        repeat (3) @(posedge pclk);
        chk({crit_oe, lim_oe}, 2'h3);
        apb(1'b1, 6'h03, 32'h00);
        sense_temp <= 16'h0300;
        repeat (2 * CONV + 4) @(posedge pclk);
        chk({crit_oe, lim_oe}, 2'h1);
        $display("test alerts done");
        apb(1'b1, 6'h03, 32'h60);
        span(2'h0, 8'h10, 8'h11, CONV, CONV);
        apb(1'b1, 6'h03, 32'h60);
        span(2'h2, 8'h12, 8'h13, OCONV, 45);
        apb(1'b1, 6'h03, 32'h60);
        sense_temp <= 16'h1400;
        repeat (2 * CONV) @(posedge pclk);
        apb(1'b0, 6'h00, 32'h0);
        chk(rd, 32'h13);
        sense_temp <= 16'h3000;
        apb(1'b1, 6'h03, 32'h30);
        repeat (CONV + 6) @(posedge pclk);
        chk(lim_oe, 1'b1);
        apb(1'b0, 6'h00, 32'h0);
        chk(rd, 32'h30);
        repeat (2) @(posedge pclk);
        chk(lim_oe, 1'b0);
        sense_temp <= 16'h1500;
        repeat (2 * CONV) @(posedge pclk);
        apb(1'b0, 6'h00, 32'h0);
        chk(rd, 32'h30);
        apb(1'b1, 6'h03, 32'h30);
        repeat (CONV + 6) @(posedge pclk);
        apb(1'b0, 6'h00, 32'h0);
        chk(rd, 32'h15);
        $display("test one-shot done");
        apb(1'b0, 6'h08, 32'h0);
        n0 = rd;
        scl_go <= 1'b1;
        repeat (50) @(posedge pclk);
        scl_go <= 1'b0;
        apb(1'b0, 6'h08, 32'h0);
        chk(rd, n0 + 32'h5);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 6'h03, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 6'h08, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        wrap_up;
    end
endmodule
